// ---- bcmc_top.v ----
// boot, system clock and memory map control with APB registers
// assumes oscillator outputs arrive as asynchronous pins on pclk,
// option straps and watchdog expiry come from logic on pclk
`timescale 1ns/1ps
`include "bcmc_defines.vh"

module bcmc_top #(
  parameter BOOT_FAST_CYC = `BCMC_BOOT_FAST,
  parameter BOOT_SLOW_CYC = `BCMC_BOOT_SLOW
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        fast_rc_oscillator,
  input  wire        slow_rc_oscillator,
  input  wire        low_voltage_reset_detector,
  input  wire        reset_pin_n,
  input  wire        wdt_expire,
  input  wire        boot_slow_option,
  input  wire [2:0]  calibration_directive,
  input  wire        irq_take,
  input  wire [9:0]  prog_addr,
  output wire        prog_addr_user,
  output wire        prog_addr_sys,
  output reg         pc_load,
  output reg  [9:0]  pc_load_addr,
  output reg         cpu_run,
  output wire        fast_osc_en,
  output wire        slow_osc_en,
  output wire [7:0]  fast_trim,
  output reg         wdt_enable,
  output reg         port_a_bit5_pin_oe,
  output reg         sys_clk_tick
);

  localparam ST_LATCH = 2'd0;
  localparam ST_BOOT  = 2'd1;
  localparam ST_RUN   = 2'd2;

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  // RQ9 code decode
  function [2:0] mode_sel;
    input [7:0] code;
    begin
      case (code)
        `BCMC_CM_DIV2:  mode_sel = 3'd0;
        `BCMC_CM_DIV4:  mode_sel = 3'd1;
        `BCMC_CM_DIV8:  mode_sel = 3'd2;
        // RQ10 further codes
        `BCMC_CM_DIV16: mode_sel = 3'd3;
        `BCMC_CM_DIV32: mode_sel = 3'd4;
        `BCMC_CM_DIV64: mode_sel = 3'd5;
        `BCMC_CM_SLOW:  mode_sel = `BCMC_SEL_SLOW;
        default:        mode_sel = `BCMC_SEL_NONE;
      endcase
    end
  endfunction

  function [7:0] cal_code;
    input [2:0] opt;
    begin
      case (opt)
        3'd1:    cal_code = `BCMC_CM_DIV2;
        3'd2:    cal_code = `BCMC_CM_DIV4;
        3'd3:    cal_code = `BCMC_CM_DIV8;
        3'd4:    cal_code = `BCMC_CM_DIV16;
        3'd5:    cal_code = `BCMC_CM_DIV32;
        default: cal_code = `BCMC_CM_SLOW;
      endcase
    end
  endfunction

  // ----------------------------------------
  // program map
  // ----------------------------------------
  // RQ3 system area
  assign prog_addr_sys  = (prog_addr >= `BCMC_SYS_LO);
  // RQ4 user space
  assign prog_addr_user = !prog_addr_sys && (prog_addr != `BCMC_RESET_VEC)
                          && (prog_addr != `BCMC_IRQ_VEC);

  // ----------------------------------------
  // synchronisers and edge detect
  // ----------------------------------------
  reg [2:0] fast_sy_r;
  reg [2:0] slow_sy_r;
  reg [1:0] lvr_sy_r;
  reg [1:0] pin_sy_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_sy_r <= 3'b000;
      slow_sy_r <= 3'b000;
      lvr_sy_r  <= 2'b00;
      pin_sy_r  <= 2'b11;
    end else begin
      fast_sy_r <= {fast_sy_r[1:0], fast_rc_oscillator};
      slow_sy_r <= {slow_sy_r[1:0], slow_rc_oscillator};
      lvr_sy_r  <= {lvr_sy_r[0], low_voltage_reset_detector};
      pin_sy_r  <= {pin_sy_r[0], reset_pin_n};
    end
  end

  // edges judged on stages two and three only
  wire fast_tick = fast_sy_r[1] & ~fast_sy_r[2];
  wire slow_tick = slow_sy_r[1] & ~slow_sy_r[2];
  wire lvr_evt   = lvr_sy_r[1];
  wire pin_evt   = ~pin_sy_r[1];
  wire rst_evt   = lvr_evt | pin_evt | wdt_expire;

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  reg  [1:0]  state_r;
  reg  [11:0] boot_cnt_r;
  reg         boot_slow_r;
  reg  [7:0]  clkmd_r;
  reg  [7:0]  trim_r;
  reg  [3:0]  cause_r;
  reg  [5:0]  sp_r;
  reg  [5:0]  ptr_r;
  reg  [8:0]  bitsel_r;
  reg  [7:0]  dmem [0:63];

  wire        booting = (state_r != ST_RUN);
  // RQ7 both forced on while booting
  // RQ6 independent enable bits
  assign fast_osc_en = booting | clkmd_r[`BCMC_FAST_BIT];
  assign slow_osc_en = booting | clkmd_r[`BCMC_SLOW_BIT];
  // RQ15 trim drives the oscillator
  assign fast_trim   = trim_r;

  wire [11:0] boot_lim = boot_slow_r ? BOOT_SLOW_CYC[11:0] - 12'h001
                                     : BOOT_FAST_CYC[11:0] - 12'h001;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire wr_acc  = access & pwrite;
  wire rd_acc  = access & ~pwrite;
  wire is_dmem = (paddr[11:8] == 4'h1) && (paddr[1:0] == 2'b00);
  wire [5:0] dm_a = paddr[7:2];
  wire hit = is_dmem || (paddr == `BCMC_OFS_CLKMD) || (paddr == `BCMC_OFS_TRIM)
             || (paddr == `BCMC_OFS_STAT) || (paddr == `BCMC_OFS_SP)
             || (paddr == `BCMC_OFS_PTR) || (paddr == `BCMC_OFS_IND)
             || (paddr == `BCMC_OFS_BITSEL) || (paddr == `BCMC_OFS_BITDAT)
             || (paddr == `BCMC_OFS_STACK);
  // zero wait states; data is prepared during setup
  assign pready = 1'b1;

  // RQ17 pointer byte chooses the target byte
  wire [5:0] ind_a  = dmem[ptr_r][5:0];
  wire [5:0] bit_a  = bitsel_r[5:0];
  wire [2:0] bit_n  = bitsel_r[8:6];
  wire [5:0] pop_a  = sp_r - 6'd1;
  wire [2:0] act_sel;

  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (is_dmem) begin
      rd_nxt[7:0] = dmem[dm_a];
    end else begin
      case (paddr)
        `BCMC_OFS_CLKMD:  rd_nxt[7:0] = clkmd_r;
        `BCMC_OFS_TRIM:   rd_nxt[7:0] = trim_r;
        `BCMC_OFS_STAT:   rd_nxt[11:0] = {act_sel, port_a_bit5_pin_oe, wdt_enable,
                                          cpu_run, cause_r, boot_slow_r, 1'b0};
        `BCMC_OFS_SP:     rd_nxt[5:0] = sp_r;
        `BCMC_OFS_PTR:    rd_nxt[5:0] = ptr_r;
        `BCMC_OFS_IND:    rd_nxt[7:0] = dmem[ind_a];
        `BCMC_OFS_BITSEL: rd_nxt[8:0] = bitsel_r;
        // RQ16 single bit read
        `BCMC_OFS_BITDAT: rd_nxt[0] = dmem[bit_a][bit_n];
        // RQ18 pop reads below the pointer
        `BCMC_OFS_STACK:  rd_nxt[7:0] = dmem[pop_a];
        default:          rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr <= ~hit;
    end
  end

  // ----------------------------------------
  // data memory
  // ----------------------------------------
  // no reset: contents are undefined after power-up, as in sram
  always @(posedge pclk) begin
    if (wr_acc) begin
      if (is_dmem) begin
        // RQ16 byte write
        dmem[dm_a] <= pwdata[7:0];
      end else if (paddr == `BCMC_OFS_IND) begin
        // RQ17 indirect write
        dmem[ind_a] <= pwdata[7:0];
      end else if (paddr == `BCMC_OFS_BITDAT) begin
        // RQ16 single bit write
        dmem[bit_a][bit_n] <= pwdata[0];
      end else if (paddr == `BCMC_OFS_STACK) begin
        // RQ18 push at the pointer
        dmem[sp_r] <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // boot sequencer and control registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r            <= ST_LATCH;
      boot_cnt_r         <= 12'h000;
      boot_slow_r        <= 1'b0;
      clkmd_r            <= `BCMC_CM_SLOW;
      trim_r             <= `BCMC_TRIM_RST;
      cause_r            <= 4'h1;
      sp_r               <= 6'h00;
      ptr_r              <= 6'h00;
      bitsel_r           <= 9'h000;
      pc_load            <= 1'b0;
      pc_load_addr       <= `BCMC_RESET_VEC;
      cpu_run            <= 1'b0;
      wdt_enable         <= 1'b0;
      port_a_bit5_pin_oe <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      // software clears cause bits by writing ones; new events win
      if (wr_acc && paddr == `BCMC_OFS_STAT) begin
        cause_r <= (cause_r & ~pwdata[5:2]) | {wdt_expire, pin_evt, lvr_evt, 1'b0};
      end else begin
        cause_r <= cause_r | {wdt_expire, pin_evt, lvr_evt, 1'b0};
      end
      if (wr_acc && paddr == `BCMC_OFS_TRIM) begin
        trim_r <= pwdata[7:0];
      end
      if (wr_acc && paddr == `BCMC_OFS_PTR) begin
        ptr_r <= pwdata[5:0];
      end
      if (wr_acc && paddr == `BCMC_OFS_BITSEL) begin
        bitsel_r <= pwdata[8:0];
      end
      // RQ18 software placed stack pointer
      if (wr_acc && paddr == `BCMC_OFS_SP) begin
        sp_r <= pwdata[5:0];
      end else if (wr_acc && paddr == `BCMC_OFS_STACK) begin
        sp_r <= sp_r + 6'd1;
      end else if (rd_acc && paddr == `BCMC_OFS_STACK) begin
        sp_r <= pop_a;
      end
      case (state_r)
        ST_LATCH: begin
          // straps caught after presetn release, and again on every reset event while it is held
          boot_slow_r <= boot_slow_option;
          boot_cnt_r  <= 12'h000;
          cpu_run     <= 1'b0;
          // RQ13 boot value follows the boot option
          clkmd_r     <= boot_slow_option ? `BCMC_CM_SLOW : `BCMC_CM_DIV64;
          state_r     <= ST_BOOT;
        end
        ST_BOOT: begin
          // RQ19 any source restarts the delay
          if (rst_evt) begin
            state_r <= ST_LATCH;
          end else if (slow_tick) begin
            // RQ5 selectable boot delay
            if (boot_cnt_r == boot_lim) begin
              state_r      <= ST_RUN;
              cpu_run      <= 1'b1;
              // RQ1 first fetch at zero
              pc_load      <= 1'b1;
              pc_load_addr <= `BCMC_RESET_VEC;
              // RQ14 watchdog on without calibration
              wdt_enable   <= (calibration_directive == `BCMC_CAL_NONE);
              // RQ12 pin stays input either way
              port_a_bit5_pin_oe <= 1'b0;
              if (calibration_directive != `BCMC_CAL_NONE) begin
                // RQ12 calibrated clock mode applied
                clkmd_r <= cal_code(calibration_directive);
              end
            end else begin
              boot_cnt_r <= boot_cnt_r + 12'h001;
            end
          end
        end
        ST_RUN: begin
          if (rst_evt) begin
            // RQ19 reboot on any source
            state_r <= ST_LATCH;
            cpu_run <= 1'b0;
          end else if (irq_take) begin
            // RQ2 interrupt entry
            pc_load      <= 1'b1;
            pc_load_addr <= `BCMC_IRQ_VEC;
          end
          if (wr_acc && paddr == `BCMC_OFS_CLKMD) begin
            // RQ11 slow code clears the fast enable bit itself
            clkmd_r <= pwdata[7:0];
          end
        end
        default: begin
          state_r <= ST_LATCH;
        end
      endcase
    end
  end

  // ----------------------------------------
  // system clock enable generator
  // ----------------------------------------
  reg  [2:0] act_r;
  reg  [5:0] div_cnt_r;
  wire [2:0] req_sel = mode_sel(clkmd_r);
  wire       act_slow = (act_r == `BCMC_SEL_SLOW);
  wire [5:0] div_lim  = (6'd2 << act_r) - 6'd1;
  // RQ8 only the two oscillators feed the tick
  wire       src_tick = act_slow ? (slow_tick & slow_osc_en)
                                 : (fast_tick & fast_osc_en);
  wire       period_end = act_slow ? src_tick : (src_tick && div_cnt_r == div_lim);
  wire       src_dead   = act_slow ? ~slow_osc_en : ~fast_osc_en;
  assign act_sel = act_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r        <= `BCMC_SEL_SLOW;
      div_cnt_r    <= 6'h00;
      sys_clk_tick <= 1'b0;
    end else begin
      sys_clk_tick <= period_end;
      // RQ20 switch at a period boundary, or at once when the active source is disabled
      if ((period_end || src_dead) && req_sel != `BCMC_SEL_NONE) begin
        act_r     <= req_sel;
        div_cnt_r <= 6'h00;
      end else if (period_end) begin
        div_cnt_r <= 6'h00;
      end else if (src_tick) begin
        div_cnt_r <= div_cnt_r + 6'd1;
      end
    end
  end

endmodule // bcmc_top

// ---- bcmc_defines.vh ----
// constants of the boot, clock and memory map control block
// assumes a 12-bit APB byte address and a 10-bit program counter
//
// Function
// RQ1 - every reset starts fetch at program address zero
// RQ2 - a taken interrupt vectors to the fixed entry address
// RQ3 - top sixteen program words are system area, not user code
// RQ4 - user space is 0x001-0x00f and 0x011-0x3ef
// RQ5 - boot waits 32 or 2048 slow oscillator cycles, by option
// RQ6 - clock mode bits 4 and 2 enable fast and slow oscillators
// RQ7 - both oscillators run while boot is in progress
// RQ8 - system clock comes only from the fast or slow oscillator
// RQ9 - codes 34h, 14h, 3ch give fast divided by 2, 4, 8
// RQ10 - codes 1ch, 7ch give fast /16, /32; e4h gives slow
// RQ11 - slow oscillator selected means fast oscillator off
// RQ12 - with calibration: watchdog off, slow running, port a bit5 input
// RQ13 - without calibration clock mode keeps boot value, slow or fast/64
// RQ14 - without calibration: watchdog on, slow running, bit5 input
// RQ15 - writable trim register adjusts fast oscillator frequency
// RQ16 - data memory allows byte and single bit access
// RQ17 - any of 64 bytes can serve as pointer to any byte
// RQ18 - stack lives in data memory at the stack pointer
// RQ19 - every reset source restarts the boot delay counter
// RQ20 - clock source or divider switches without short pulses
`ifndef BCMC_DEFINES_VH
`define BCMC_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define BCMC_OFS_CLKMD  12'h000
`define BCMC_OFS_TRIM   12'h004
`define BCMC_OFS_STAT   12'h008
`define BCMC_OFS_SP     12'h00c
`define BCMC_OFS_PTR    12'h010
`define BCMC_OFS_IND    12'h014
`define BCMC_OFS_BITSEL 12'h018
`define BCMC_OFS_BITDAT 12'h01c
`define BCMC_OFS_STACK  12'h020
`define BCMC_OFS_DMEM   6'h01
// ----------------------------------------
// program map
// ----------------------------------------
`define BCMC_RESET_VEC  10'h000
`define BCMC_IRQ_VEC    10'h010
`define BCMC_SYS_LO     10'h3f0
// ----------------------------------------
// clock mode codes and fields
// ----------------------------------------
`define BCMC_CM_DIV2    8'h34
`define BCMC_CM_DIV4    8'h14
`define BCMC_CM_DIV8    8'h3c
`define BCMC_CM_DIV16   8'h1c
`define BCMC_CM_DIV32   8'h7c
`define BCMC_CM_SLOW    8'he4
`define BCMC_CM_DIV64   8'h94
`define BCMC_FAST_BIT   4
`define BCMC_SLOW_BIT   2
`define BCMC_SEL_SLOW   3'd6
`define BCMC_SEL_NONE   3'd7
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define BCMC_TRIM_RST   8'h80
`define BCMC_BOOT_FAST  32
`define BCMC_BOOT_SLOW  2048
`define BCMC_CAL_NONE   3'd0

`endif

// ---- bcmc_top_assertions.sv ----
// port checker for the boot, clock and map control block
// assumes oscillator pins toggle no faster than every other pclk
`timescale 1ns/1ps
module bcmc_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        wdt_expire,
  input wire [2:0]  calibration_directive,
  input wire        irq_take,
  input wire [9:0]  prog_addr,
  input wire        prog_addr_user,
  input wire        prog_addr_sys,
  input wire        pc_load,
  input wire [9:0]  pc_load_addr,
  input wire        cpu_run,
  input wire        fast_osc_en,
  input wire        slow_osc_en,
  input wire        wdt_enable,
  input wire        port_a_bit5_pin_oe,
  input wire        sys_clk_tick
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------------
  // assertions
  // ------------------------------------
  AST_USER_SPACE:
    assert property (prog_addr_user == (prog_addr != 10'h000 && prog_addr != 10'h010
                     && prog_addr < 10'h3f0)) else $error("user space flag wrong");
  AST_SYS_AREA:
    assert property (prog_addr_sys == (prog_addr >= 10'h3f0)) else $error("system flag wrong");
  AST_BOOT_VEC:
    assert property (pc_load && !$past(cpu_run) |-> pc_load_addr == 10'h000 ##[0:1] cpu_run)
      else $error("boot fetch not at zero");
  AST_IRQ_VEC:
    assert property (cpu_run && irq_take && !wdt_expire |=> pc_load && pc_load_addr == 10'h010)
      else $error("interrupt entry wrong");
  AST_PC_PULSE:
    assert property (pc_load |=> !pc_load) else $error("pc load longer than one cycle");
  AST_BOOT_OSC:
    assert property (!cpu_run |-> fast_osc_en && slow_osc_en) else $error("oscillator off in boot");
  AST_BOOT_STATE:
    assert property ($rose(cpu_run) |-> slow_osc_en && wdt_enable == (calibration_directive == 3'd0))
      else $error("state after boot wrong");
  AST_PA5_IN:
    assert property (!port_a_bit5_pin_oe) else $error("port a bit5 driven");
  AST_TICK_GAP:
    assert property (sys_clk_tick |=> !sys_clk_tick [*3]) else $error("short system clock period");
  AST_RESTART:
    assert property (wdt_expire |-> ##[1:3] !cpu_run) else $error("watchdog did not restart boot");
  // ------------------------------------
  // covers
  // ------------------------------------
  CV_BOOT: cover property ($rose(cpu_run));
  CV_IRQ: cover property (pc_load && pc_load_addr == 10'h010);
  CV_TICK: cover property (sys_clk_tick);
  CV_WDT: cover property (wdt_expire && cpu_run);
endmodule // bcmc_chk

bind bcmc_top bcmc_chk u_chk (
  .pclk, .presetn, .wdt_expire, .calibration_directive, .irq_take, .prog_addr,
  .prog_addr_user, .prog_addr_sys, .pc_load, .pc_load_addr, .cpu_run, .fast_osc_en,
  .slow_osc_en, .wdt_enable, .port_a_bit5_pin_oe, .sys_clk_tick
);

// ---- bcmc_top_tb.sv ----
// self-checking bench for bcmc_top
// assumes the checker binds itself; boot counts shortened to 4 and 8
`timescale 1ns/1ps
`include "bcmc_defines.vh"
module bcmc_top_tb;
  reg         pclk, presetn, psel, penable, pwrite, irq_take, boot_slow_option;
  reg         fast_rc_oscillator, slow_rc_oscillator, low_voltage_reset_detector;
  reg         reset_pin_n, wdt_expire;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd, v;
  reg  [2:0]  calibration_directive;
  reg  [9:0]  prog_addr;
  reg  [7:0]  k;
  reg  [5:0]  p;
  reg         err;
  wire        pready, pslverr, prog_addr_user, prog_addr_sys, pc_load, cpu_run;
  wire        fast_osc_en, slow_osc_en, wdt_enable, port_a_bit5_pin_oe, sys_clk_tick;
  wire [31:0] prdata;
  wire [9:0]  pc_load_addr;
  wire [7:0]  fast_trim;
  integer     fails, checks_done, seed, i, n, t, oc;

  bcmc_top #(.BOOT_FAST_CYC(4), .BOOT_SLOW_CYC(8)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .fast_rc_oscillator, .slow_rc_oscillator, .low_voltage_reset_detector,
    .reset_pin_n, .wdt_expire, .boot_slow_option, .calibration_directive, .irq_take,
    .prog_addr, .prog_addr_user, .prog_addr_sys, .pc_load, .pc_load_addr, .cpu_run,
    .fast_osc_en, .slow_osc_en, .fast_trim, .wdt_enable, .port_a_bit5_pin_oe, .sys_clk_tick
  );

  // ------------------------------------
  // clock and oscillators
  // ------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // fast rises every 4 cycles, slow every 20
  always @(posedge pclk) begin
    oc <= oc + 1;
    if (oc % 2 == 1) fast_rc_oscillator <= ~fast_rc_oscillator;
    if (oc % 10 == 9) slow_rc_oscillator <= ~slow_rc_oscillator;
  end

  // ------------------------------------
  // tasks and functions
  // ------------------------------------
  task chk(input [31:0] s, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask

  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait limit here: only the global timeout ends a stuck transfer
      do @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  function [7:0] exp_code(input [2:0] c, input so);
    case (c)
      3'd0: exp_code = so ? 8'he4 : 8'h94;
      3'd1: exp_code = 8'h34;
      3'd2: exp_code = 8'h14;
      3'd3: exp_code = 8'h3c;
      3'd4: exp_code = 8'h1c;
      3'd5: exp_code = 8'h7c;
      default: exp_code = 8'he4;
    endcase
  endfunction

  // program map corners around the vectors and the system area
  function [9:0] corner(input [2:0] j);
    case (j)
      3'd0: corner = 10'h000;
      3'd1: corner = 10'h001;
      3'd2: corner = 10'h00f;
      3'd3: corner = 10'h010;
      3'd4: corner = 10'h011;
      3'd5: corner = 10'h3ef;
      3'd6: corner = 10'h3f0;
      default: corner = 10'h3ff;
    endcase
  endfunction

  // cycles per system clock with a 4-cycle fast and 20-cycle slow source
  function integer exp_gap(input [7:0] c);
    case (c)
      8'h34: exp_gap = 8;
      8'h14: exp_gap = 16;
      8'h3c: exp_gap = 32;
      8'h1c: exp_gap = 64;
      8'h7c: exp_gap = 128;
      default: exp_gap = 20;
    endcase
  endfunction

  // restarts from one reset source and times the boot delay
  task boot(input [1:0] src, input so, input [2:0] c);
    begin
      boot_slow_option <= so;
      calibration_directive <= c;
      presetn <= (src != 2'd0);
      low_voltage_reset_detector <= (src == 2'd1);
      reset_pin_n <= (src != 2'd2);
      wdt_expire <= (src == 2'd3);
      repeat (4) @(posedge pclk);
      chk(cpu_run, 0);
      presetn <= 1'b1;
      low_voltage_reset_detector <= 1'b0;
      reset_pin_n <= 1'b1;
      wdt_expire <= 1'b0;
      t = 0;
      while (cpu_run !== 1'b1 && t < 5000) begin
        @(posedge pclk);
        t = t + 1;
      end
      n = so ? 160 : 80;
      chk(t >= n - 20 && t <= n + 28, 1);
    end
  endtask

  // length of the third system clock period seen
  task gap;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        t = 1;
        @(posedge pclk);
        while (sys_clk_tick !== 1'b1 && t < 600) begin
          @(posedge pclk);
          t = t + 1;
        end
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  initial begin
    #(25 * 60000);
    fails = fails + 1;
    report_and_stop;
  end

  // ------------------------------------
  // main sequence
  // ------------------------------------
  initial begin
    {psel, penable, pwrite, irq_take, fast_rc_oscillator, slow_rc_oscillator} = 6'h00;
    {paddr, pwdata, prog_addr} = 0;
    fails = 0;
    checks_done = 0;
    seed = 10;
    oc = 0;
    boot(2'd0, 1'b0, 3'd0);
    apb(0, `BCMC_OFS_TRIM, 0);
    chk(rd[7:0], 8'h80);
    for (p = 0; p < 8; p = p + 1) begin
      // one drawn option feeds both the strap and the expectation
      v = $random(seed);
      v[0] = v[0] | (p == 1);
      k = exp_code((p < 2) ? 3'd0 : p[2:0] - 3'd1, v[0]);
      boot(p[1:0], v[0], (p < 2) ? 3'd0 : p[2:0] - 3'd1);
      apb(0, `BCMC_OFS_CLKMD, 0);
      chk(rd[7:0], (p == 0 || p > 1) ? k : 8'he4);
      chk(pc_load_addr, 0);
      chk(wdt_enable, p < 2);
      chk(slow_osc_en, 1);
      chk(fast_osc_en, rd[7:0] != 8'he4);
    end
    for (p = 1; p < 7; p = p + 1) begin
      k = exp_code(p[2:0], 1'b0);
      apb(1, `BCMC_OFS_CLKMD, {24'h0, k});
      apb(0, `BCMC_OFS_CLKMD, 0);
      chk(rd[7:0], k);
      gap;
      chk(t, exp_gap(k));
    end
    irq_take <= 1'b1;
    @(posedge pclk);
    irq_take <= 1'b0;
    t = 0;
    while (pc_load !== 1'b1 && t < 10) begin
      @(posedge pclk);
      t = t + 1;
    end
    chk(pc_load_addr, 10'h010);
    v = $random(seed);
    apb(1, `BCMC_OFS_TRIM, v);
    apb(0, `BCMC_OFS_TRIM, 0);
    chk(rd, {24'h0, v[7:0]});
    chk(fast_trim, v[7:0]);
    for (i = 0; i < 24; i = i + 1) begin
      prog_addr <= (i < 8) ? corner(i[2:0]) : $random(seed);
      @(posedge pclk);
      @(posedge pclk);
      chk(prog_addr_user, prog_addr != 0 && prog_addr != 10'h010 && prog_addr < 10'h3f0);
      chk(prog_addr_sys, prog_addr >= 10'h3f0);
    end
    p = $random(seed);
    apb(1, 12'h100 + 4 * p, {26'h0, p ^ 6'h20});
    apb(1, 12'h100 + 4 * (p ^ 6'h20), {24'h0, v[15:8]});
    apb(1, `BCMC_OFS_PTR, {26'h0, p});
    apb(0, `BCMC_OFS_IND, 0);
    chk(rd[7:0], v[15:8]);
    apb(1, `BCMC_OFS_BITSEL, {23'h0, v[18:16], p ^ 6'h20});
    apb(0, `BCMC_OFS_BITDAT, 0);
    chk(rd[0], v[8 + v[18:16]]);
    apb(1, `BCMC_OFS_BITDAT, {31'h0, ~rd[0]});
    apb(0, 12'h100 + 4 * (p ^ 6'h20), 0);
    chk(rd[7:0], v[15:8] ^ (8'h01 << v[18:16]));
    apb(1, `BCMC_OFS_SP, {26'h0, p});
    apb(1, `BCMC_OFS_STACK, {24'h0, v[31:24]});
    apb(0, 12'h100 + 4 * p, 0);
    chk(rd[7:0], v[31:24]);
    apb(0, `BCMC_OFS_STACK, 0);
    chk(rd[7:0], v[31:24]);
    // every reset source has been seen once; run is up on the slow source
    apb(0, `BCMC_OFS_STAT, 0);
    chk(rd[6:2], 5'h1f);
    chk(rd[11:9], `BCMC_SEL_SLOW);
    apb(1, `BCMC_OFS_STAT, 32'h0000_003c);
    apb(0, `BCMC_OFS_STAT, 0);
    chk(rd[5:2], 4'h0);
    apb(0, 12'h024, 0);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    report_and_stop;
  end
endmodule // bcmc_top_tb
